// ===== sta_pkg.sv
// Shared constants, register map and carrier types of the sequential trigger block
package sta_pkg;
	// Clock rates and the elapsed-time source
	localparam int CLK_MHZ       = 100;
	localparam int TIMER_SRC_MHZ = 10;
	localparam int TICK_DIV      = CLK_MHZ / TIMER_SRC_MHZ;
	// Structure sizes
	localparam int LEVELS    = 16;
	localparam int PTR_W     = 4;
	localparam int MAR_W     = 10;
	localparam int CNT_W     = 16;
	localparam int PROBES    = 3;
	localparam int CHAN      = 8;
	localparam int WORD_W    = PROBES * CHAN;
	localparam int QWORDS    = 4;
	localparam int OCC_W     = 8;
	localparam int ADDR_W    = 6;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_MAR    = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_SSEL   = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_SPAT   = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_SMASK  = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_SLEVEL = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_QSEL   = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_QPAT   = 6'h28;
	localparam logic [ADDR_W-1:0] OFS_QMASK  = 6'h2c;
	localparam logic [ADDR_W-1:0] OFS_MADDR  = 6'h30;
	localparam logic [ADDR_W-1:0] OFS_MDATA  = 6'h34;
	// Control register command bits
	localparam int CTRL_INIT  = 0;
	localparam int CTRL_START = 1;
	localparam int CTRL_WCLR  = 2;
	// Level entry bit positions
	localparam int LV_START = 8;
	localparam int LV_STOP  = 9;
	localparam int LV_BUMP  = 10;
	localparam int LV_TRIG  = 11;
	// Configuration word
	typedef struct packed {
		logic       restartEn;
		logic [1:0] restartIdx;
		logic       expansion;
		logic       demux;
		logic       timerMode;
		logic [1:0] masterSel;
	} sta_cfg_type;
	localparam sta_cfg_type CFG_RESET = '0;
	// Per-level reaction and occurrence count
	typedef struct packed {
		logic             fireTrigger;
		logic             levelBumpsEventCount;
		logic             stopTimer;
		logic             startTimer;
		logic [OCC_W-1:0] count;
	} sta_level_type;
	// Avalon-MM request bundle
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [31:0]       writedata;
		logic [3:0]        byteenable;
	} sta_avreq_type;
endpackage : sta_pkg

// ===== sta_seq_trigger.sv
// Sequential stack recognizer, counter/timer, trigger and acquisition memory
//
// Behaviour
// - Load occurrence count on start and level entry
// - Count only when local and expansion matches
// - Exhausted occurrence count advances the pointer
// - Initialization clears the stack pointer
// - Broadcast pointer advance to expansion modules
// - Restart word forces pointer to zero
// - Counter/timer is event counter or 10 MHz timer
// - Timer runs from start level until stop/trigger
// - Counter mode counts completed flagged levels
// - 16-bit counter interrupts host on wrap
// - Trigger pulls active-low trigger event line
// - Low stop qualifier holds the address register
// - Ten-bit address register follows master clock
// - Held address rewrites the same location
// - Memory writes one word each master cycle while running
// - Configuration selects one of three probe clocks as master
// - Qualifier words need all modules matching
// - Expansion compares selected word, returns match
// - Expansion pointer follows master advance pulses
// - Login registers per probe clock, optional demux
`timescale 1ns/1ps
module sta_seq_trigger
	import sta_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst_n,
	// Avalon-MM slave
	input  wire sta_pkg::sta_avreq_type   avReq,
	output logic [31:0]                   avReadData,
	output logic                          avWaitRequest,
	// Probe pins
	input  wire logic [sta_pkg::PROBES-1:0] probeClk,
	input  wire logic [sta_pkg::WORD_W-1:0] probeData,
	// Time-base link
	output logic                          triggerEvent_n,
	input  wire logic                     acquisitionStopQual_n,
	// Expansion lines, open drain except the pointer advance broadcast
	input  wire logic                     stackMatchReturnLineIn,
	output logic                          stackMatchReturnLineOut,
	output logic                          stackMatchReturnLineOe,
	input  wire logic                     pointerAdvanceBroadcastIn,
	output logic                          pointerAdvanceBroadcast,
	input  wire logic [1:0]               qualifierMatchShareAIn,
	output logic [1:0]                    qualifierMatchShareAOut,
	output logic [1:0]                    qualifierMatchShareAOe,
	input  wire logic [1:0]               qualifierMatchShareBIn,
	output logic [1:0]                    qualifierMatchShareBOut,
	output logic [1:0]                    qualifierMatchShareBOe,
	// Host interrupt on counter wrap
	output logic                          hostIrq
);
	import sta_pkg::*;

	localparam int SYNC_W = PROBES * (CHAN + 1) + 7;
	initial
	begin
		if (TICK_DIV < 1) $error("clock too slow for timer source");
	end

	// Two-stage synchronisers for every pin input
	logic [SYNC_W-1:0] syncA;
	logic [SYNC_W-1:0] syncB;
	logic [PROBES-1:0] clkPrev;            // Previous synced probe clocks
	logic              advPrev;            // Previous synced advance line
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA   <= '0;
			syncB   <= '0;
			clkPrev <= '0;
			advPrev <= 1'b0;
		end
		else
		begin
			syncA   <= {probeClk, probeData, acquisitionStopQual_n, stackMatchReturnLineIn,
				pointerAdvanceBroadcastIn, qualifierMatchShareAIn, qualifierMatchShareBIn};
			syncB   <= syncA;
			clkPrev <= syncB[SYNC_W-1 -: PROBES];
			advPrev <= syncB[4];
		end
	end
	// Synced views, taken from the second stage only
	logic [PROBES-1:0] clkS;
	logic [WORD_W-1:0] dataS;
	logic              stopLow;            // Stop qualifier asserted
	logic              matchRetS;          // Wired-AND stack match
	logic [3:0]        qShareS;            // Wired-AND qualifier matches
	logic [PROBES-1:0] clkRise;            // One-cycle edge of each probe clock
	logic              advRise;            // Advance pulse from master
	assign clkS      = syncB[SYNC_W-1 -: PROBES];
	assign dataS     = syncB[SYNC_W-PROBES-1 -: WORD_W];
	assign stopLow   = !syncB[6];
	assign matchRetS = syncB[5];
	assign qShareS   = {syncB[1:0], syncB[3:2]}; // Words 3:2 on B, 1:0 on A
	assign clkRise   = clkS & ~clkPrev;
	assign advRise   = syncB[4] & ~advPrev;

	// Configuration and command strobes
	sta_cfg_type cfg;
	logic        initCmd;                  // One-cycle initialisation
	logic        startCmd;                 // One-cycle start of acquisition
	logic        wrapClr;                  // Host acknowledges wrap
	logic        masterTick;               // Edge of selected master clock
	assign masterTick = clkRise[(cfg.masterSel < 2'(PROBES)) ? cfg.masterSel : 2'h0];

	// Login registers, each probe on its own clock
	logic [WORD_W-1:0] login;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			login <= '0;
		else
		begin
			for (int p = 0; p < PROBES; p++)
			begin
				// Demux steers probe A into the B slot on the B clock
				if (clkRise[p])
					login[p*CHAN +: CHAN] <= (cfg.demux && p == 1) ? dataS[0 +: CHAN]
						: dataS[p*CHAN +: CHAN];
			end
		end
	end

	// Data register on the master clock
	logic [WORD_W-1:0] dataReg;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			dataReg <= '0;
		else if (masterTick)
			dataReg <= login;
	end

	// Stack and qualifier tables
	logic [WORD_W-1:0] stackPat  [LEVELS];
	logic [WORD_W-1:0] stackMask [LEVELS];
	sta_level_type     levelRam  [LEVELS];
	logic [WORD_W-1:0] qualPat   [QWORDS];
	logic [WORD_W-1:0] qualMask  [QWORDS];
	logic [PTR_W-1:0]  stackPtr;
	logic [PTR_W-1:0]  ptrNext;
	assign ptrNext = (stackPtr == PTR_W'(LEVELS - 1)) ? stackPtr : stackPtr + 1'b1;

	// Recognizers
	logic             stackLocal;          // Selected stack word matches here
	logic             stackAll;            // Matched by every module
	logic [QWORDS-1:0] qualLocal;          // Local slice matches
	logic [QWORDS-1:0] qualAll;            // Recognised by every module
	assign stackLocal = ((dataReg ^ stackPat[stackPtr]) & stackMask[stackPtr]) == '0;
	assign stackAll   = stackLocal && matchRetS;
	always_comb
	begin
		for (int q = 0; q < QWORDS; q++)
			qualLocal[q] = ((dataReg ^ qualPat[q]) & qualMask[q]) == '0;
	end
	assign qualAll = qualLocal & qShareS;

	// Sequence state
	logic              running;
	logic              triggered;
	logic [OCC_W-1:0]  occCount;
	logic              restartHit;         // Restart word seen this cycle
	logic              levelDone;          // Current level completes
	logic              advance;            // Pointer steps this cycle
	sta_level_type     curLevel;
	sta_level_type     newLevel;
	assign curLevel   = levelRam[stackPtr];
	assign newLevel   = levelRam[ptrNext];
	assign restartHit = masterTick && running && cfg.restartEn && qualAll[cfg.restartIdx];
	assign levelDone  = masterTick && running && !cfg.expansion && stackAll && occCount <= 1;
	assign advance    = cfg.expansion ? advRise : levelDone;

	// Stack pointer
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			stackPtr <= '0;
		else if (initCmd || startCmd)
			stackPtr <= '0;
		else if (restartHit)
			stackPtr <= '0;
		else if (advance)
			stackPtr <= ptrNext;
	end

	// Occurrence counter, reloaded on each level entry
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			occCount <= '0;
		else if (initCmd)
			occCount <= '0;
		else if (startCmd || restartHit)
			occCount <= levelRam[0].count;
		else if (advance)
			occCount <= newLevel.count;
		else if (masterTick && running && stackAll && occCount != '0)
			occCount <= occCount - 1'b1;
	end

	// Run flag and trigger
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			running   <= 1'b0;
			triggered <= 1'b0;
		end
		else if (initCmd)
		begin
			running   <= 1'b0;
			triggered <= 1'b0;
		end
		else if (startCmd)
			running <= 1'b1;
		else if (levelDone && curLevel.fireTrigger)
			triggered <= 1'b1;
	end

	// Expansion and time-base outputs
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			triggerEvent_n          <= 1'b1;
			pointerAdvanceBroadcast <= 1'b0;
			stackMatchReturnLineOut <= 1'b0;
			stackMatchReturnLineOe  <= 1'b0;
			qualifierMatchShareAOut <= '0;
			qualifierMatchShareBOut <= '0;
			qualifierMatchShareAOe  <= '0;
			qualifierMatchShareBOe  <= '0;
		end
		else
		begin
			triggerEvent_n <= !(triggered || (levelDone && curLevel.fireTrigger)) || initCmd;
			// Held until the next master edge so slower modules see it
			if (levelDone)
				pointerAdvanceBroadcast <= 1'b1;
			else if (masterTick || initCmd)
				pointerAdvanceBroadcast <= 1'b0;
			stackMatchReturnLineOe <= cfg.expansion && !stackLocal;
			qualifierMatchShareAOe <= ~qualLocal[1:0];
			qualifierMatchShareBOe <= ~qualLocal[3:2];
		end
	end

	// Memory address register and acquisition memory
	logic [WORD_W-1:0] acqMem [2**MAR_W];
	logic [MAR_W-1:0]  mar;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mar <= '0;
		else if (initCmd)
			mar <= '0;
		else if (masterTick && running && !stopLow)
			mar <= mar + 1'b1;
	end
	always_ff @(posedge clk_sys)
	begin
		// Held address overwrites one cell, older data survives
		if (masterTick && running)
			acqMem[mar] <= login;
	end

	// Counter/timer with wrap flag
	logic [CNT_W-1:0] counter;
	logic [3:0]       tickDiv;
	logic             timerRun;
	logic             wrapEv;              // Counter wraps this cycle
	logic             bumpEv;              // Count or time step
	assign bumpEv = cfg.timerMode ? (timerRun && tickDiv == 4'(TICK_DIV - 1))
		: (levelDone && curLevel.levelBumpsEventCount);
	assign wrapEv = bumpEv && counter == '1;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tickDiv <= '0;
		else if (tickDiv == 4'(TICK_DIV - 1) || initCmd)
			tickDiv <= '0;
		else
			tickDiv <= tickDiv + 1'b1;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			timerRun <= 1'b0;
		else if (initCmd || triggerEvent_n == 1'b0)
			timerRun <= 1'b0;
		else if (levelDone && curLevel.stopTimer)
			timerRun <= 1'b0;
		// Running is still low in the start cycle itself
		else if (cfg.timerMode && ((startCmd && levelRam[0].startTimer)
			|| (running && advance && newLevel.startTimer)))
			timerRun <= 1'b1;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			counter <= '0;
		else if (initCmd)
			counter <= '0;
		else if (bumpEv)
			counter <= counter + 1'b1;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			hostIrq <= 1'b0;
		else if (wrapEv)
			hostIrq <= 1'b1;
		else if (wrapClr)
			hostIrq <= 1'b0;
	end

	// Avalon-MM slave, one wait cycle then answer
	logic [PTR_W-1:0] stackSel;
	logic [1:0]       qualSel;
	logic [MAR_W-1:0] memAddr;
	logic             busHit;              // Request taken this cycle
	logic             busPend;             // Answer cycle in progress
	logic             busWr;               // Write completes this cycle
	logic [31:0]      beMask;
	logic [31:0]      wd;
	assign busHit = (avReq.read || avReq.write) && avWaitRequest && !busPend;
	// Writes land only at the edge where waitrequest is sampled low
	assign busWr  = avReq.write && !avWaitRequest;
	assign beMask = {{8{avReq.byteenable[3]}}, {8{avReq.byteenable[2]}},
		{8{avReq.byteenable[1]}}, {8{avReq.byteenable[0]}}};
	assign wd     = avReq.writedata & beMask;
	assign initCmd  = busWr && avReq.address == OFS_CTRL && wd[CTRL_INIT];
	assign startCmd = busWr && avReq.address == OFS_CTRL && wd[CTRL_START];
	assign wrapClr  = busWr && avReq.address == OFS_CTRL && wd[CTRL_WCLR];
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			avWaitRequest <= 1'b1;
			busPend       <= 1'b0;
			avReadData    <= '0;
		end
		else
		begin
			avWaitRequest <= !busHit;
			busPend       <= busHit;
			if (busHit && avReq.read)
			begin
				case (avReq.address)
					OFS_CONFIG: avReadData <= 32'(cfg);
					OFS_STATUS: avReadData <= 32'({hostIrq, timerRun, stopLow, triggered,
						running, stackPtr});
					OFS_COUNT:  avReadData <= 32'(counter);
					OFS_MAR:    avReadData <= 32'(mar);
					OFS_MDATA:  avReadData <= 32'(acqMem[memAddr]);
					default:    avReadData <= '0;
				endcase
			end
		end
	end
	// Register writes into configuration and tables
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg      <= CFG_RESET;
			stackSel <= '0;
			qualSel  <= '0;
			memAddr  <= '0;
		end
		else if (busWr)
		begin
			case (avReq.address)
				OFS_CONFIG: cfg      <= sta_cfg_type'(wd[$bits(sta_cfg_type)-1:0]);
				OFS_SSEL:   stackSel <= wd[PTR_W-1:0];
				OFS_QSEL:   qualSel  <= wd[1:0];
				OFS_MADDR:  memAddr  <= wd[MAR_W-1:0];
				default:    ;
			endcase
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (busWr)
		begin
			case (avReq.address)
				OFS_SPAT:   stackPat[stackSel]  <= wd[WORD_W-1:0];
				OFS_SMASK:  stackMask[stackSel] <= wd[WORD_W-1:0];
				OFS_SLEVEL: levelRam[stackSel]  <= sta_level_type'(wd[LV_TRIG:0]);
				OFS_QPAT:   qualPat[qualSel]    <= wd[WORD_W-1:0];
				OFS_QMASK:  qualMask[qualSel]   <= wd[WORD_W-1:0];
				default:    ;
			endcase
		end
	end

	// Checks
	property p_ptrInit;
		@(posedge clk_sys) disable iff (!rst_n) initCmd |=> stackPtr == '0;
	endproperty
	a_ptrInit: assert property (p_ptrInit) else $error("pointer not cleared");
	property p_restart;
		@(posedge clk_sys) disable iff (!rst_n) restartHit |=> stackPtr == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("restart ignored");
	sequence s_stepLevel;
		levelDone && !restartHit && !initCmd;
	endsequence
	property p_advance;
		@(posedge clk_sys) disable iff (!rst_n)
			s_stepLevel |=> pointerAdvanceBroadcast && stackPtr == $past(ptrNext);
	endproperty
	a_advance: assert property (p_advance) else $error("advance not sent");
	property p_occHold;
		@(posedge clk_sys) disable iff (!rst_n)
			!stackAll && !advance && !initCmd && !startCmd && !restartHit
			|=> $stable(occCount);
	endproperty
	a_occHold: assert property (p_occHold) else $error("count moved without match");
	property p_trig;
		@(posedge clk_sys) disable iff (!rst_n)
			levelDone && curLevel.fireTrigger && !initCmd |=> !triggerEvent_n [*2];
	endproperty
	a_trig: assert property (p_trig) else $error("trigger line not low");
	property p_marHold;
		@(posedge clk_sys) disable iff (!rst_n) stopLow && !initCmd |=> $stable(mar);
	endproperty
	a_marHold: assert property (p_marHold) else $error("address moved while stopped");
	property p_marInc;
		@(posedge clk_sys) disable iff (!rst_n)
			masterTick && running && !stopLow && !initCmd |=> mar == $past(mar) + 1'b1;
	endproperty
	a_marInc: assert property (p_marInc) else $error("address did not step");
	property p_wrap;
		@(posedge clk_sys) disable iff (!rst_n) wrapEv |=> hostIrq && counter == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap not flagged");
	property p_timerRate;
		@(posedge clk_sys) disable iff (!rst_n)
			cfg.timerMode && bumpEv && !initCmd |=> !bumpEv [*8];
	endproperty
	a_timerRate: assert property (p_timerRate) else $error("timer faster than source");
endmodule : sta_seq_trigger

// ===== sta_time_base_model.sv
// Time-base board and expansion-side model facing the trigger block
`timescale 1ns/1ps
module sta_time_base_model
#(
	parameter int DELAY = 20 // Post-trigger delay in clocks
)
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Trigger link
	input  wire logic triggerEvent_n,
	output logic      acquisitionStopQual_n,
	// Expansion side
	input  wire logic vetoMatch,
	output logic      matchPull
);
	int delayCnt; // Clocks since the trigger fell

	// Delay count after the trigger, then stop the acquisition
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			delayCnt              <= 0;
			acquisitionStopQual_n <= 1'b1;
		end
		else if (triggerEvent_n)
		begin
			delayCnt              <= 0;
			acquisitionStopQual_n <= 1'b1;
		end
		else if (delayCnt < DELAY)
			delayCnt <= delayCnt + 1;
		else
			acquisitionStopQual_n <= 1'b0;
	end

	// Expansion that misses its slice pulls the shared match line low
	assign matchPull = vetoMatch;
endmodule : sta_time_base_model

// ===== sta_seq_trigger_test.sv
// Self-checking bench for the sequential trigger block
`timescale 1ns/1ps
module sta_seq_trigger_test;
	import sta_pkg::*;
	// Expected read result, with the bits that matter
	typedef struct packed {
		logic [5:0]  addr;
		logic [31:0] exp;
		logic [31:0] mask;
	} sta_expect_type;
	logic              clk_sys;               // System clock
	logic              rst_n;                 // Reset, active low
	sta_avreq_type     avReq;                 // Bus request
	logic [31:0]       avReadData;            // Read data
	logic              avWaitRequest;         // Bus stall
	logic [PROBES-1:0] probeClk;              // Probe clocks
	logic [WORD_W-1:0] probeData;             // Probe data
	logic              triggerEvent_n;        // Trigger line
	logic              acquisitionStopQual_n; // Stop qualifier
	logic              vetoMatch;             // Expansion misses its slice
	logic              matchPull;             // Expansion pulls match line
	logic              matchOe;               // Local stack veto
	logic [1:0]        shAOe;                 // Local qualifier vetoes
	logic [1:0]        shBOe;
	logic              bcast;                 // Pointer advance pulse
	logic              bcastPrev;
	logic              advIn;                 // Advance pulse from a master
	sta_expect_type    expQ[$];               // Pending read notes
	sta_expect_type    note;
	logic [23:0]       sent[0:63];            // Words fed, by feed number
	logic [23:0]       w;
	int                nSent;
	int                nBcast;
	int                nMismatch;
	int                testsRun;

	// System clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	sta_seq_trigger DUT (
		.clk_sys(clk_sys), .rst_n(rst_n), .avReq(avReq), .avReadData(avReadData),
		.avWaitRequest(avWaitRequest), .probeClk(probeClk), .probeData(probeData),
		.triggerEvent_n(triggerEvent_n), .acquisitionStopQual_n(acquisitionStopQual_n),
		.stackMatchReturnLineIn(~(matchOe | matchPull)), .stackMatchReturnLineOut(),
		.stackMatchReturnLineOe(matchOe), .pointerAdvanceBroadcastIn(advIn),
		.pointerAdvanceBroadcast(bcast), .qualifierMatchShareAIn(~shAOe),
		.qualifierMatchShareAOut(), .qualifierMatchShareAOe(shAOe),
		.qualifierMatchShareBIn(~shBOe), .qualifierMatchShareBOut(),
		.qualifierMatchShareBOe(shBOe), .hostIrq()
	);

	sta_time_base_model PARTNER (
		.clk_sys(clk_sys), .rst_n(rst_n), .triggerEvent_n(triggerEvent_n),
		.acquisitionStopQual_n(acquisitionStopQual_n), .vetoMatch(vetoMatch),
		.matchPull(matchPull)
	);

	// Verdict and end of run
	task automatic conclude;
		$display("Checks %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// Compare a bus word under a mask
	task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] m,
		input logic [31:0] s);
		testsRun++;
		if ((s & m) !== (e & m))
		begin
			nMismatch++;
			$display("FAIL %s expected %h seen %h", what, e & m, s & m);
		end
	endtask : cmp_word

	// Compare a single line
	task automatic cmp_bit(input string what, input logic e, input logic s);
		testsRun++;
		if (s !== e)
		begin
			nMismatch++;
			$display("FAIL %s expected %b seen %b", what, e, s);
		end
	endtask : cmp_bit

	// One bus access, held until waitrequest is sampled low
	task automatic av(input logic [5:0] a, input logic rd, input logic [31:0] d);
		int n;
		n = 0;
		avReq <= '{address: a, read: rd, write: ~rd, writedata: d, byteenable: 4'hf};
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avWaitRequest !== 1'b0 && n < 50);
		if (n >= 50)
			nMismatch++;
		avReq.read  <= 1'b0;
		avReq.write <= 1'b0;
		@(posedge clk_sys);
	endtask : av

	// Register read with its expectation noted
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back('{addr: a, exp: e, mask: m});
		av(a, 1'b1, 32'h0);
	endtask : rd

	// One probe sample, one link clock period of 80 ns
	task automatic feed(input logic [23:0] d);
		probeData <= d;
		sent[nSent % 64] = d;
		nSent++;
		repeat (4) @(posedge clk_sys);
		probeClk <= '1;
		repeat (4) @(posedge clk_sys);
		probeClk <= '0;
	endtask : feed

	// A word, then a random non-matching word twice
	task automatic word_then_idle(input logic [23:0] d);
		logic [23:0] idle;
		idle = 24'($urandom() & 32'h3fffff);
		feed(d);
		feed(idle);
		feed(idle);
	endtask : word_then_idle

	// Watcher takes the oldest note on each read answer
	always @(posedge clk_sys)
	begin
		if (avReq.read === 1'b1 && avWaitRequest === 1'b0 && expQ.size() > 0)
		begin
			note = expQ.pop_front();
			cmp_word($sformatf("read %h", note.addr), note.exp, note.mask, avReadData);
		end
		bcastPrev <= bcast;
		if (bcast === 1'b1 && bcastPrev !== 1'b1)
			nBcast++;
	end

	// Watchdog against a hang
	initial
	begin
		#200000;
		nMismatch++;
		conclude();
	end

	// Main sequence
	initial
	begin
		rst_n     <= 1'b0;
		avReq     <= '0;
		probeClk  <= '0;
		probeData <= '0;
		vetoMatch <= 1'b0;
		advIn     <= 1'b0;
		nSent = 0;
		nBcast = 0;
		nMismatch = 0;
		testsRun = 0;
		void'($urandom(1));
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Stop qualifier needs its synchroniser filled first
		repeat (3) @(posedge clk_sys);
		rd(OFS_STATUS, 32'h0, 32'h1ff);
		rd(OFS_CONFIG, 32'h0, 32'hff);
		rd(6'h3c, 32'h0, 32'hffffffff);
		av(OFS_CONFIG, 1'b0, 32'h80);
		rd(OFS_CONFIG, 32'h80, 32'hff);
		// Level 0 twice, level 1 fires, others never match
		for (int i = 0; i < LEVELS; i++)
		begin
			av(OFS_SSEL, 1'b0, i);
			av(OFS_SPAT, 1'b0, i == 0 ? 32'h400001 : i == 1 ? 32'h400002 : 32'hffffff);
			av(OFS_SMASK, 1'b0, 32'hffffff);
			av(OFS_SLEVEL, 1'b0, i == 0 ? 32'h402 : i == 1 ? 32'hc01 : 32'h1);
		end
		// Qualifier 0 is the restart word
		for (int q = 0; q < QWORDS; q++)
		begin
			av(OFS_QSEL, 1'b0, q);
			av(OFS_QPAT, 1'b0, q == 0 ? 32'h400003 : 32'hffffff);
			av(OFS_QMASK, 1'b0, 32'hffffff);
		end
		av(OFS_CTRL, 1'b0, 32'h1);
		av(OFS_CTRL, 1'b0, 32'h2);
		vetoMatch <= 1'b1;
		word_then_idle(24'h400001);
		vetoMatch <= 1'b0;
		rd(OFS_STATUS, 32'h10, 32'h3f);
		word_then_idle(24'h400001);
		rd(OFS_STATUS, 32'h10, 32'h3f);
		word_then_idle(24'h400001);
		rd(OFS_STATUS, 32'h11, 32'h3f);
		rd(OFS_COUNT, 32'h1, 32'hffff);
		rd(OFS_MAR, nSent, 32'h3ff);
		word_then_idle(24'h400003);
		rd(OFS_STATUS, 32'h10, 32'h2f);
		word_then_idle(24'h400001);
		word_then_idle(24'h400001);
		rd(OFS_STATUS, 32'h11, 32'h2f);
		word_then_idle(24'h400002);
		rd(OFS_STATUS, 32'h22, 32'h2f);
		rd(OFS_COUNT, 32'h3, 32'hffff);
		cmp_bit("triggerEvent_n", 1'b0, triggerEvent_n);
		for (int n = 0; n < 200 && acquisitionStopQual_n !== 1'b0; n++)
			@(posedge clk_sys);
		repeat (6) @(posedge clk_sys);
		rd(OFS_STATUS, 32'h40, 32'h40);
		w = 24'($urandom() & 32'h3fffff);
		feed(w);
		feed(w);
		rd(OFS_MAR, nSent - 2, 32'h3ff);
		av(OFS_MADDR, 1'b0, nSent - 2);
		rd(OFS_MDATA, w, 32'hffffff);
		av(OFS_MADDR, 1'b0, 32'h2);
		// Cell k holds the sample fed before the k-th master tick
		rd(OFS_MDATA, sent[1], 32'hffffff);
		cmp_word("advance pulses", 32'h3, 32'hffffffff, nBcast);
		av(OFS_CTRL, 1'b0, 32'h1);
		rd(OFS_STATUS, 32'h0, 32'h3f);
		rd(OFS_COUNT, 32'h0, 32'hffff);
		rd(OFS_MAR, 32'h0, 32'h3ff);
		cmp_bit("triggerEvent_n", 1'b1, triggerEvent_n);
		// Timer mode starts at level 0 on start
		av(OFS_CONFIG, 1'b0, 32'h4);
		av(OFS_SSEL, 1'b0, 32'h0);
		av(OFS_SLEVEL, 1'b0, 32'h102);
		av(OFS_CTRL, 1'b0, 32'h2);
		repeat (40) @(posedge clk_sys);
		rd(OFS_STATUS, 32'h90, 32'hff);
		av(OFS_CTRL, 1'b0, 32'h1);
		rd(OFS_STATUS, 32'h0, 32'hff);
		// Expansion mode follows the advance line
		av(OFS_CONFIG, 1'b0, 32'h10);
		av(OFS_CTRL, 1'b0, 32'h2);
		advIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		advIn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(OFS_STATUS, 32'h11, 32'hff);
		cmp_bit("stackMatchReturnLineOe", 1'b1, matchOe);
		repeat (4) @(posedge clk_sys);
		conclude();
	end
endmodule : sta_seq_trigger_test
